// [src/root_hub_pkg.sv]
// Constants shared by the root hub descriptor register logic.
package root_hub_pkg;
  // Command codes on the host command interface.
  localparam logic [7:0] RD_DESC_FIRST = 8'h12;
  localparam logic [7:0] WR_DESC_FIRST = 8'h92;
  localparam logic [7:0] RD_DESC_SECOND = 8'h13;
  localparam logic [7:0] WR_DESC_SECOND = 8'h93;
  localparam logic [7:0] RD_HUB_STATUS = 8'h14;
  localparam logic [7:0] WR_HUB_STATUS = 8'h94;
  localparam logic [7:0] RD_PORT_STATUS_BASE = 8'h15;
  localparam logic [7:0] WR_PORT_STATUS_BASE = 8'h95;

  // Fixed sizes.
  localparam int NUM_PORTS = 2;
  localparam logic [1:0] PORT_COUNT = 2'h2;

  // First descriptor field positions.
  localparam int PGD_LSB = 24;
  localparam int NO_OC_PROTECT_BIT = 12;
  localparam int OC_MODE_BIT = 11;
  localparam int COMPOUND_BIT = 10;
  localparam int ALWAYS_POWERED_BIT = 9;
  localparam int SWITCH_MODE_BIT = 8;
  localparam int PORT_COUNT_LSB = 0;

  // Second descriptor field positions.
  localparam int POWER_MASK_LSB = 16;
  localparam int DR_LSB = 0;

  // Hub and port status command bits.
  localparam int HUB_CLR_GLOBAL_BIT = 0;
  localparam int HUB_SET_GLOBAL_BIT = 16;
  localparam int PORT_POWER_BIT = 8;
  localparam int PORT_SET_POWER_BIT = 8;
  localparam int PORT_CLR_POWER_BIT = 9;

  // Reset values; the overcurrent mode follows the switching mode.
  localparam logic [7:0] PGD_RESET = 8'h01;
  localparam logic NO_OC_PROTECT_RESET = 1'b0;
  localparam logic ALWAYS_POWERED_RESET = 1'b0;
  localparam logic SWITCH_MODE_RESET = 1'b1;
  localparam logic OC_MODE_RESET = SWITCH_MODE_RESET;
  localparam logic [1:0] POWER_MASK_RESET = 2'h0;
  localparam logic [1:0] DR_RESET = 2'h0;
endpackage

// [src/port_power_ctl.sv]
// Power switch state of one downstream root hub port.
`timescale 1ns/1ps
module port_power_ctl (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Configuration.
  input wire logic always_powered_i,
  input wire logic switch_mode_i,
  input wire logic mask_i,
  // Power commands, one-cycle pulses.
  input wire logic global_set_i,
  input wire logic global_clr_i,
  input wire logic port_set_i,
  input wire logic port_clr_i,
  // Port power state.
  output logic power_o
);
  logic use_port_cmd;

  // Individual mode with the mask set routes the port to its own commands only.
  assign use_port_cmd = switch_mode_i && mask_i;

  // Power state; always-powered ports ignore every command.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      power_o <= 1'b0;
    end else if (always_powered_i) begin
      power_o <= 1'b1;
    end else if (use_port_cmd) begin
      if (port_set_i) begin
        power_o <= 1'b1;
      end else if (port_clr_i) begin
        power_o <= 1'b0;
      end
    end else begin
      if (global_set_i) begin
        power_o <= 1'b1;
      end else if (global_clr_i) begin
        power_o <= 1'b0;
      end
    end
  end
endmodule

// [src/root_hub_desc_regs.sv]
// Root hub descriptor registers with state-gated status writes.
//
// Overview of operation
// - Every register is read and written as one whole 32-bit word.
// - Both descriptor words accept writes in every controller USB state.
// - Hub and port status writes take effect only in the operational state.
// - First descriptor reads with code 12h and writes with code 92h.
// - Bit 12 set means no overcurrent reporting; clear lets bit 11 choose.
// - Bit 11 picks collective (0) or per-port (1) overcurrent reporting.
// - Overcurrent mode resets to the same value as the switching mode.
// - Compound device flag at bit 10 always reads zero; writes ignored.
// - Bit 9 clear means switched ports; set means always powered.
// - Bit 8 picks ganged (0) or individual (1) port power switching.
// - In individual mode masked ports obey per-port commands only; all other ports obey global only.
// - Bits 1 to 0 read the downstream port count, which is 2.
// - Power mask sits in bits 18 to 16; bit n is port n; bit 0 reserved.
`timescale 1ns/1ps
module root_hub_desc_regs (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Host command interface.
  input wire logic [7:0] CMD_CODE_I,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic [31:0] WR_DATA_I,
  output logic [31:0] RD_DATA_O,
  output logic RD_VALID_O,
  // Controller state.
  input wire logic OPERATIONAL_I,
  // Root hub configuration and port power.
  output logic OC_REPORT_EN_O,
  output logic OC_PER_PORT_O,
  output logic [1:0] PORT_POWER_O
);
  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0] power_good_delay;
  logic no_overcurrent_protect;
  logic overcurrent_report_mode;
  logic always_powered_flag;
  logic power_switch_mode;
  logic [1:0] port_power_mask;
  logic [1:0] device_removable;
  logic [31:0] next_rd_data;
  logic [31:0] desc_first_word;
  logic [31:0] desc_second_word;
  logic wr_first;
  logic wr_second;
  logic status_wr_ok;
  logic global_set;
  logic global_clr;
  logic [1:0] port_set;
  logic [1:0] port_clr;
  logic [1:0] port_rd_hit;

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  // Descriptor writes are never gated on the controller state.
  assign wr_first = CMD_WR_I && (CMD_CODE_I == root_hub_pkg::WR_DESC_FIRST);
  assign wr_second = CMD_WR_I && (CMD_CODE_I == root_hub_pkg::WR_DESC_SECOND);
  // Status writes only count in the operational state.
  assign status_wr_ok = CMD_WR_I && OPERATIONAL_I;
  assign global_set = status_wr_ok && (CMD_CODE_I == root_hub_pkg::WR_HUB_STATUS)
    && WR_DATA_I[root_hub_pkg::HUB_SET_GLOBAL_BIT];
  assign global_clr = status_wr_ok && (CMD_CODE_I == root_hub_pkg::WR_HUB_STATUS)
    && WR_DATA_I[root_hub_pkg::HUB_CLR_GLOBAL_BIT];

  // First descriptor: whole-word write of the writable fields only.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      power_good_delay <= root_hub_pkg::PGD_RESET;
      no_overcurrent_protect <= root_hub_pkg::NO_OC_PROTECT_RESET;
      overcurrent_report_mode <= root_hub_pkg::OC_MODE_RESET;
      always_powered_flag <= root_hub_pkg::ALWAYS_POWERED_RESET;
      power_switch_mode <= root_hub_pkg::SWITCH_MODE_RESET;
    end else if (wr_first) begin
      power_good_delay <= WR_DATA_I[root_hub_pkg::PGD_LSB +: 8];
      no_overcurrent_protect <= WR_DATA_I[root_hub_pkg::NO_OC_PROTECT_BIT];
      overcurrent_report_mode <= WR_DATA_I[root_hub_pkg::OC_MODE_BIT];
      always_powered_flag <= WR_DATA_I[root_hub_pkg::ALWAYS_POWERED_BIT];
      power_switch_mode <= WR_DATA_I[root_hub_pkg::SWITCH_MODE_BIT];
    end
  end

  // Second descriptor: mask and removable bits for ports 1 and 2.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      port_power_mask <= root_hub_pkg::POWER_MASK_RESET;
      device_removable <= root_hub_pkg::DR_RESET;
    end else if (wr_second) begin
      port_power_mask <= WR_DATA_I[root_hub_pkg::POWER_MASK_LSB + 1 +: 2];
      device_removable <= WR_DATA_I[root_hub_pkg::DR_LSB + 1 +: 2];
    end
  end

  // ---------------------------------------------------------------------------
  // Port power
  // ---------------------------------------------------------------------------
  // One power controller per port; port n uses the n-th status code.
  generate
    for (genvar p = 0; p < root_hub_pkg::NUM_PORTS; p++) begin : g_port
      assign port_set[p] = status_wr_ok
        && (CMD_CODE_I == root_hub_pkg::WR_PORT_STATUS_BASE + 8'(p))
        && WR_DATA_I[root_hub_pkg::PORT_SET_POWER_BIT];
      assign port_clr[p] = status_wr_ok
        && (CMD_CODE_I == root_hub_pkg::WR_PORT_STATUS_BASE + 8'(p))
        && WR_DATA_I[root_hub_pkg::PORT_CLR_POWER_BIT];
      assign port_rd_hit[p] = (CMD_CODE_I == root_hub_pkg::RD_PORT_STATUS_BASE + 8'(p));
      port_power_ctl u_power (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .always_powered_i(always_powered_flag),
        .switch_mode_i(power_switch_mode),
        .mask_i(port_power_mask[p]),
        .global_set_i(global_set),
        .global_clr_i(global_clr),
        .port_set_i(port_set[p]),
        .port_clr_i(port_clr[p]),
        .power_o(PORT_POWER_O[p])
      );
    end
  endgenerate

  // Overcurrent reporting mode seen by the port logic.
  assign OC_REPORT_EN_O = !no_overcurrent_protect;
  assign OC_PER_PORT_O = !no_overcurrent_protect && overcurrent_report_mode;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Whole-word images; reserved and compound device bits are zero.
  always_comb begin
    desc_first_word = 32'h0;
    desc_first_word[root_hub_pkg::PGD_LSB +: 8] = power_good_delay;
    desc_first_word[root_hub_pkg::NO_OC_PROTECT_BIT] = no_overcurrent_protect;
    desc_first_word[root_hub_pkg::OC_MODE_BIT] = overcurrent_report_mode;
    desc_first_word[root_hub_pkg::COMPOUND_BIT] = 1'b0;
    desc_first_word[root_hub_pkg::ALWAYS_POWERED_BIT] = always_powered_flag;
    desc_first_word[root_hub_pkg::SWITCH_MODE_BIT] = power_switch_mode;
    desc_first_word[root_hub_pkg::PORT_COUNT_LSB +: 2] = root_hub_pkg::PORT_COUNT;
    desc_second_word = 32'h0;
    desc_second_word[root_hub_pkg::POWER_MASK_LSB + 1 +: 2] = port_power_mask;
    desc_second_word[root_hub_pkg::DR_LSB + 1 +: 2] = device_removable;
  end

  // Read multiplexer; unknown codes read as zero.
  always_comb begin
    next_rd_data = 32'h0;
    if (CMD_CODE_I == root_hub_pkg::RD_DESC_FIRST) begin
      next_rd_data = desc_first_word;
    end else if (CMD_CODE_I == root_hub_pkg::RD_DESC_SECOND) begin
      next_rd_data = desc_second_word;
    end else if (port_rd_hit[0]) begin
      next_rd_data[root_hub_pkg::PORT_POWER_BIT] = PORT_POWER_O[0];
    end else if (port_rd_hit[1]) begin
      next_rd_data[root_hub_pkg::PORT_POWER_BIT] = PORT_POWER_O[1];
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      RD_DATA_O <= 32'h0;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= CMD_RD_I;
      if (CMD_RD_I) begin
        RD_DATA_O <= next_rd_data;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_read_first;
    CMD_RD_I && (CMD_CODE_I == root_hub_pkg::RD_DESC_FIRST);
  endsequence

  sequence s_gated_status_wr;
    CMD_WR_I && !OPERATIONAL_I && (CMD_CODE_I == root_hub_pkg::WR_HUB_STATUS
      || CMD_CODE_I == root_hub_pkg::WR_PORT_STATUS_BASE
      || CMD_CODE_I == root_hub_pkg::WR_PORT_STATUS_BASE + 8'h01);
  endsequence

  a_read_latency: assert property (CMD_RD_I |=> RD_VALID_O)
    else $error("Read answer not given one cycle after the strobe.");
  a_first_write_any: assert property (wr_first |=>
    power_good_delay == $past(WR_DATA_I[31:24]))
    else $error("First descriptor write did not land.");
  a_status_write_gated: assert property (s_gated_status_wr |=>
    $stable(PORT_POWER_O) || always_powered_flag)
    else $error("Status write acted outside the operational state.");
  a_first_read_image: assert property (s_read_first ##1 1 |->
    RD_DATA_O[root_hub_pkg::PGD_LSB +: 8] == power_good_delay
    && RD_DATA_O[root_hub_pkg::COMPOUND_BIT] == 1'b0)
    else $error("First descriptor read image is wrong.");
  // The reporting outputs must agree with the word that software reads back.
  a_oc_mode_select: assert property (s_read_first |=>
    OC_PER_PORT_O == (!RD_DATA_O[root_hub_pkg::NO_OC_PROTECT_BIT]
    && RD_DATA_O[root_hub_pkg::OC_MODE_BIT])
    && OC_REPORT_EN_O == !RD_DATA_O[root_hub_pkg::NO_OC_PROTECT_BIT])
    else $error("Overcurrent reporting mode output is wrong.");
  a_overcurrent_report_mode_reset_value: assert property ($past(RESET_I) |->
    overcurrent_report_mode == power_switch_mode)
    else $error("Overcurrent mode did not reset to the switching mode.");
  a_reserved_zero: assert property (s_read_first |=> RD_DATA_O[23:13] == 11'h0
    && RD_DATA_O[7:2] == 6'h0 && RD_DATA_O[1:0] == 2'h2)
    else $error("Reserved bits or port count read wrong.");
  a_always_powered: assert property (always_powered_flag |=> PORT_POWER_O == 2'h3)
    else $error("Always powered ports are not powered.");
  a_mask_per_port: assert property (global_set && power_switch_mode
    && port_power_mask[0] && !always_powered_flag && !port_set[0] |=>
    PORT_POWER_O[0] == $past(PORT_POWER_O[0]))
    else $error("Masked port followed a global power command.");
endmodule

// [testbench/tb_top.sv]
// Self-checking testbench for the root hub descriptor register block.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] cmd_code = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic operational = 1'b0;
  logic [31:0] rd_data;
  logic rd_valid;
  logic oc_en;
  logic oc_per_port;
  logic [1:0] port_power;
  int failures = 0;
  int compares = 0;

  root_hub_desc_regs root_hub_desc_regs_i (
    .CLK_I(clk), .RESET_I(reset), .CMD_CODE_I(cmd_code), .CMD_WR_I(cmd_wr),
    .CMD_RD_I(cmd_rd), .WR_DATA_I(wr_data), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .OPERATIONAL_I(operational), .OC_REPORT_EN_O(oc_en), .OC_PER_PORT_O(oc_per_port),
    .PORT_POWER_O(port_power)
  );

  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Issues one whole-word write as a one-cycle strobe.
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    @(posedge clk);
    cmd_code <= code;
    wr_data <= data;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask

  // Issues one read and checks the answer in the cycle after the strobe.
  task automatic rd(input logic [7:0] code, input logic [31:0] exp);
    @(posedge clk);
    cmd_code <= code;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1;
    chk("rd_valid", 32'h1, {31'h0, rd_valid});
    chk("rd_data", exp, rd_data);
    @(posedge clk);
    #1;
    chk("rd_valid_drop", 32'h0, {31'h0, rd_valid});
  endtask

  // Lets a write reach the port power outputs, then checks them.
  task automatic chk_power(input logic [1:0] exp);
    repeat (2) @(posedge clk);
    #1;
    chk("port_power", {30'h0, exp}, {30'h0, port_power});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("oc_en_reset", 32'h1, {31'h0, oc_en});
    chk("oc_per_port_reset", 32'h1, {31'h0, oc_per_port});
    chk("port_power_reset", 32'h0, {30'h0, port_power});
    // Reset word: delay 1, mode bits equal, two ports, compound flag clear.
    rd(root_hub_pkg::RD_DESC_FIRST, 32'h01000902);
    // All ones outside the operational state: read-only and reserved bits hold.
    wr(root_hub_pkg::WR_DESC_FIRST, 32'hffffffff);
    rd(root_hub_pkg::RD_DESC_FIRST, 32'hff001b02);
    chk("oc_en_no_overcurrent_protect", 32'h0, {31'h0, oc_en});
    chk("oc_per_port_no_overcurrent_protect", 32'h0, {31'h0, oc_per_port});
    chk_power(2'h3);
    // Clearing everything keeps the port count and selects collective reporting.
    wr(root_hub_pkg::WR_DESC_FIRST, 32'h00000000);
    rd(root_hub_pkg::RD_DESC_FIRST, 32'h00000002);
    chk("oc_en_coll", 32'h1, {31'h0, oc_en});
    chk("oc_per_port_coll", 32'h0, {31'h0, oc_per_port});
    // Switched ports keep the power they had while always powered.
    chk_power(2'h3);
    // Ganged mode: status writes are ignored outside the operational state.
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00000001);
    chk_power(2'h3);
    @(posedge clk);
    operational <= 1'b1;
    wr(root_hub_pkg::WR_PORT_STATUS_BASE, 32'h00000200);
    chk_power(2'h3);
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00000001);
    chk_power(2'h0);
    wr(root_hub_pkg::WR_PORT_STATUS_BASE, 32'h00000100);
    chk_power(2'h0);
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00010000);
    chk_power(2'h3);
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00000001);
    chk_power(2'h0);
    // Individual mode, with per-port overcurrent reporting selected (bit 11 set).
    wr(root_hub_pkg::WR_DESC_FIRST, 32'h08000900);
    rd(root_hub_pkg::RD_DESC_FIRST, 32'h08000902);
    chk("oc_per_port_set", 32'h1, {31'h0, oc_per_port});
    // Mask bit 0 is reserved; port 1 takes per-port commands only.
    wr(root_hub_pkg::WR_DESC_SECOND, 32'h00030000);
    rd(root_hub_pkg::RD_DESC_SECOND, 32'h00020000);
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00010000);
    chk_power(2'h2);
    wr(root_hub_pkg::WR_PORT_STATUS_BASE + 8'h01, 32'h00000100);
    chk_power(2'h2);
    wr(root_hub_pkg::WR_PORT_STATUS_BASE, 32'h00000100);
    chk_power(2'h3);
    rd(root_hub_pkg::RD_PORT_STATUS_BASE, 32'h00000100);
    rd(root_hub_pkg::RD_PORT_STATUS_BASE + 8'h01, 32'h00000100);
    wr(root_hub_pkg::WR_HUB_STATUS, 32'h00000001);
    chk_power(2'h1);
    // Per-port clear is refused outside the operational state.
    @(posedge clk);
    operational <= 1'b0;
    wr(root_hub_pkg::WR_PORT_STATUS_BASE, 32'h00000200);
    chk_power(2'h1);
    @(posedge clk);
    operational <= 1'b1;
    wr(root_hub_pkg::WR_PORT_STATUS_BASE, 32'h00000200);
    chk_power(2'h0);
    // An unmapped code reads zero.
    rd(8'h7f, 32'h00000000);
    give_verdict();
  end
endmodule
